/* File: logic/ubrm_bank.sv */
/*
 * Banked UART register map behind an APB slave, zero wait states.
 * Assumes the UART data path sits beside it on the same clock and that
 * modem and gpio pins arrive asynchronously.
 */
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "ubrm_cfg.svh"

// Function
// RULE1: with divisor access clear, index 0 reads receive byte, writes transmit byte.
// RULE2: divisor access set and not enhanced bank: indices 0 and 1 reach divisor bytes.
// RULE3: fractional divisor at index 2 only with divisor access, not bank, enhancements on.
// RULE4: interrupt enable at index 1 holds the eight documented enable bits.
// RULE5: index 2 read gives source code in bits 5:0 and fifo-enabled in 7:6.
// RULE6: index 2 write enables fifos, resets them and sets both trigger selections.
// RULE7: line_control at index 3 decodes length, stop, parity, break and divisor access.
// RULE8: modem_control at index 4 outside the enhanced bank, eight documented control bits.
// RULE9: line status at index 5 is read only, eight receive and transmit flags.
// RULE10: modem status at index 6 gives four change flags and four input levels.
// RULE11: halt and resume thresholds share index 6 under the alternate selection.
// RULE12: fifo trigger levels share index 7 under the alternate selection.
// RULE13: scratch pad at index 7 returns last write with no side effect.
// RULE14: fill levels at indices 8 and 9 with bit 7 always zero.
// RULE15: gpio direction, irq enable, control read/write; pin state needs divisor access clear.
// RULE16: extra features control at index 15 is read/write.
// RULE17: enhanced bank maps index 2 to enhanced_function, 4 to 7 to flow characters.
// RULE18: extended interrupt, status, fifo and modem bits read zero unless enhancements on.
// RULE19: each access decodes index with line_control to exactly one register.
// RULE20: reserved index reads zero and ignores writes.
module ubrm_bank
    import ubrm_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [5:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    // uart data path
    input wire ubrm_stat_s STAT_IN,
    output ubrm_ctrl_s CTRL_OUT,
    output ubrm_strobe_s STROBE_OUT,
    // pins
    input wire logic [3:0] MODEM_N_IN,
    input wire logic [7:0] GPIO_IN
);
    ubrm_state_s r;
    ubrm_state_s next_r;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic enh;
    logic setup_rd;
    logic acc;
    ubrm_sel_e sel;

    // one register per index, chosen by line_control and the enhanced bits
    function automatic ubrm_sel_e sel_of(input logic [3:0] i, input logic [7:0] line_control,
                                         input logic en, input logic tsel);
        logic dlab;
        logic bank;
        logic alt;
        dlab = line_control[`UBRM_DLAB_BIT];
        bank = (line_control == `UBRM_LCR_ENH);
        alt = en & tsel;
        case (i)
            `UBRM_IDX_DATA: sel_of = dlab ? (bank ? SEL_NONE : SEL_DLL) : SEL_HOLD; // [RULE1] [RULE2]
            `UBRM_IDX_IER: sel_of = (dlab & !bank) ? SEL_DLM : SEL_IER; // [RULE2] [RULE4]
            `UBRM_IDX_ISR: sel_of = bank ? SEL_EFR : (dlab ? (en ? SEL_DLD : SEL_NONE) : SEL_ISR); // [RULE3] [RULE17]
            `UBRM_IDX_LCR: sel_of = SEL_LCR;
            `UBRM_IDX_MCR: sel_of = bank ? SEL_XON1 : SEL_MCR; // [RULE8] [RULE17]
            `UBRM_IDX_LSR: sel_of = bank ? SEL_XON2 : SEL_LSR;
            `UBRM_IDX_MSR: sel_of = bank ? SEL_XOFF1 : (alt ? SEL_TCR : SEL_MSR); // [RULE11]
            `UBRM_IDX_SPR: sel_of = bank ? SEL_XOFF2 : (alt ? SEL_TLR : SEL_SPR); // [RULE12]
            `UBRM_IDX_TX_FIFO_FILL: sel_of = SEL_TX_FIFO_FILL;
            `UBRM_IDX_RX_FIFO_FILL: sel_of = SEL_RX_FIFO_FILL;
            `UBRM_IDX_GPIO_DIRECTION: sel_of = SEL_GPIO_DIRECTION;
            `UBRM_IDX_IOST: sel_of = dlab ? SEL_NONE : SEL_IOST; // [RULE15]
            `UBRM_IDX_IOINT: sel_of = SEL_IOINT;
            `UBRM_IDX_IOCTL: sel_of = SEL_IOCTL;
            `UBRM_IDX_EXTRA_FEATURES_CONTROL: sel_of = SEL_EXTRA_FEATURES_CONTROL; // [RULE16]
            default: sel_of = SEL_NONE; // [RULE20]
        endcase
    endfunction

    // access decode shared by the read and write paths
    assign idx = PADDR_IN[5:2];
    assign wbyte = PWDATA_IN[7:0];
    assign enh = r.ctrl.enhanced_function[`UBRM_ENH_BIT];
    assign setup_rd = PSEL_IN & !PENABLE_IN & !PWRITE_IN;
    assign acc = PSEL_IN & PENABLE_IN;
    assign sel = sel_of(idx, r.ctrl.line_control, enh, r.ctrl.modem_control.internal_out1); // [RULE19]

    // next state: synchronisers, read data, write effects, strobes
    always_comb begin
        logic [7:0] rd;
        logic [3:0] chg;
        rd = 8'h00;
        chg = r.modem_sync ^ r.modem_prev;
        next_r = r;
        next_r.strobe = '0;
        next_r.modem_meta = MODEM_N_IN;
        next_r.modem_sync = r.modem_meta;
        next_r.modem_prev = r.modem_sync;
        next_r.gpio_meta = GPIO_IN;
        next_r.gpio_sync = r.gpio_meta;
        // read data sampled in the setup cycle, shown in the access cycle
        case (sel)
            SEL_HOLD: rd = STAT_IN.rx_data; // [RULE1]
            SEL_DLL: rd = r.ctrl.dll; // [RULE2]
            SEL_DLM: rd = r.ctrl.baud_divisor_high;
            SEL_DLD: rd = r.ctrl.baud_divisor_fraction; // [RULE3]
            SEL_IER: rd = r.ctrl.interrupt_enable & (enh ? 8'hff : ~`UBRM_IER_EXT_M); // [RULE4] [RULE18]
            SEL_ISR: rd = {{2{r.ctrl.fifo_control.fifo_en}},
                           STAT_IN.int_source & (enh ? 6'h3f : ~`UBRM_ISR_EXT_M)}; // [RULE5]
            SEL_EFR: rd = r.ctrl.enhanced_function;
            SEL_LCR: rd = r.ctrl.line_control; // [RULE7]
            SEL_MCR: rd = r.ctrl.modem_control & (enh ? 8'hff : ~`UBRM_MCR_EXT_M); // [RULE8] [RULE18]
            SEL_LSR: rd = STAT_IN.line_status; // [RULE9]
            SEL_MSR: rd = {~r.modem_sync, r.modem_delta}; // [RULE10]
            SEL_SPR: rd = r.ctrl.scratch_pad; // [RULE13]
            SEL_TCR: rd = r.ctrl.halt_resume_thresholds; // [RULE11]
            SEL_TLR: rd = r.ctrl.fifo_trigger_levels; // [RULE12]
            SEL_TX_FIFO_FILL: rd = {1'b0, STAT_IN.tx_fill}; // [RULE14]
            SEL_RX_FIFO_FILL: rd = {1'b0, STAT_IN.rx_fill}; // [RULE14]
            SEL_GPIO_DIRECTION: rd = r.ctrl.gpio_direction; // [RULE15]
            SEL_IOST: rd = r.gpio_sync;
            SEL_IOINT: rd = r.ctrl.io_ie;
            SEL_IOCTL: rd = r.ctrl.io_ctl;
            SEL_EXTRA_FEATURES_CONTROL: rd = r.ctrl.extra_features_control; // [RULE16]
            SEL_XON1: rd = r.ctrl.xon1; // [RULE17]
            SEL_XON2: rd = r.ctrl.xon2;
            SEL_XOFF1: rd = r.ctrl.xoff1;
            SEL_XOFF2: rd = r.ctrl.xoff2;
            default: rd = 8'h00; // [RULE20]
        endcase
        if (setup_rd) begin
            next_r.prdata = {24'h000000, rd};
        end
        // a change seen in the same cycle as the status read is kept
        if (acc && !PWRITE_IN && sel == SEL_MSR) begin
            next_r.modem_delta = chg;
        end else begin
            next_r.modem_delta = r.modem_delta | chg; // [RULE10]
        end
        // the other read with a side effect: pop the receive byte
        if (acc && !PWRITE_IN && sel == SEL_HOLD) begin
            next_r.strobe.rx_pop = 1'b1; // [RULE1]
        end
        // writes land at the access edge
        if (acc && PWRITE_IN) begin
            case (sel)
                SEL_HOLD: begin
                    next_r.ctrl.tx_data = wbyte; // [RULE1]
                    next_r.strobe.tx_load = 1'b1;
                end
                SEL_DLL: next_r.ctrl.dll = wbyte; // [RULE2]
                SEL_DLM: next_r.ctrl.baud_divisor_high = wbyte;
                SEL_DLD: next_r.ctrl.baud_divisor_fraction = wbyte; // [RULE3]
                SEL_IER: next_r.ctrl.interrupt_enable = wbyte & (enh ? 8'hff : ~`UBRM_IER_EXT_M); // [RULE18]
                SEL_ISR: begin
                    next_r.ctrl.fifo_control = wbyte & (enh ? 8'hff : ~`UBRM_FCR_EXT_M); // [RULE6]
                    next_r.ctrl.fifo_control.rx_reset = 1'b0;
                    next_r.ctrl.fifo_control.tx_reset = 1'b0;
                    next_r.strobe.rx_fifo_reset = wbyte[1]; // [RULE6]
                    next_r.strobe.tx_fifo_reset = wbyte[2];
                end
                SEL_EFR: next_r.ctrl.enhanced_function = wbyte; // [RULE17]
                SEL_LCR: next_r.ctrl.line_control = wbyte; // [RULE7]
                SEL_MCR: next_r.ctrl.modem_control = wbyte & (enh ? 8'hff : ~`UBRM_MCR_EXT_M); // [RULE8]
                SEL_SPR: next_r.ctrl.scratch_pad = wbyte; // [RULE13]
                SEL_TCR: next_r.ctrl.halt_resume_thresholds = wbyte; // [RULE11]
                SEL_TLR: next_r.ctrl.fifo_trigger_levels = wbyte; // [RULE12]
                SEL_GPIO_DIRECTION: next_r.ctrl.gpio_direction = wbyte; // [RULE15]
                SEL_IOST: next_r.ctrl.io_out = wbyte;
                SEL_IOINT: next_r.ctrl.io_ie = wbyte;
                SEL_IOCTL: next_r.ctrl.io_ctl = wbyte;
                SEL_EXTRA_FEATURES_CONTROL: next_r.ctrl.extra_features_control = wbyte; // [RULE16]
                SEL_XON1: next_r.ctrl.xon1 = wbyte; // [RULE17]
                SEL_XON2: next_r.ctrl.xon2 = wbyte;
                SEL_XOFF1: next_r.ctrl.xoff1 = wbyte;
                SEL_XOFF2: next_r.ctrl.xoff2 = wbyte;
                default: next_r.ctrl = r.ctrl; // [RULE20]
            endcase
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            r <= '0;
            r.ctrl.line_control <= `UBRM_RST_REG;
            // modem pins idle high; start the chain there so reset shows no false change
            r.modem_meta <= 4'hf;
            r.modem_sync <= 4'hf;
            r.modem_prev <= 4'hf;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign PRDATA_OUT = r.prdata;
    assign PREADY_OUT = PSEL_IN & PENABLE_IN;
    assign CTRL_OUT = r.ctrl;
    assign STROBE_OUT = r.strobe;

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    lcr_write_a: assert property ( // [RULE7]
        acc && PWRITE_IN && idx == `UBRM_IDX_LCR |=> CTRL_OUT.line_control == $past(wbyte))
        else $error("line_control not loaded");
    hold_load_a: assert property ( // [RULE1]
        acc && PWRITE_IN && sel == SEL_HOLD
        |=> STROBE_OUT.tx_load && CTRL_OUT.tx_data == $past(wbyte))
        else $error("transmit byte not loaded");
    hold_pop_a: assert property ( // [RULE1]
        acc && !PWRITE_IN && idx == `UBRM_IDX_DATA && !r.ctrl.line_control.dlab
        |=> STROBE_OUT.rx_pop ##1 !STROBE_OUT.rx_pop)
        else $error("receive pop not a single pulse");
    frac_gate_a: assert property ( // [RULE3]
        acc && PWRITE_IN && idx == `UBRM_IDX_ISR && r.ctrl.line_control.dlab && !enh
        |=> $stable(CTRL_OUT.baud_divisor_fraction))
        else $error("fractional divisor written while closed");
    ext_zero_a: assert property ( // [RULE18]
        setup_rd && idx == `UBRM_IDX_IER && !r.ctrl.line_control.dlab && !enh
        |=> PRDATA_OUT[7:4] == 4'h0)
        else $error("extended enable bits visible");
    fill_top_a: assert property ( // [RULE14]
        setup_rd && (idx == `UBRM_IDX_TX_FIFO_FILL || idx == `UBRM_IDX_RX_FIFO_FILL)
        |=> PRDATA_OUT[7] == 1'b0)
        else $error("fill level bit 7 set");
    rsvd_zero_a: assert property ( // [RULE20]
        setup_rd && idx == `UBRM_IDX_RSVD |=> PRDATA_OUT == 32'h00000000)
        else $error("reserved slot not zero");
    spr_echo_a: assert property ( // [RULE13]
        acc && PWRITE_IN && sel == SEL_SPR |=> CTRL_OUT.scratch_pad == $past(wbyte))
        else $error("scratch pad not echoed");
    modem_chg_a: assert property ( // [RULE10]
        r.modem_sync != r.modem_prev
        |=> (r.modem_delta & $past(r.modem_sync ^ r.modem_prev))
            == $past(r.modem_sync ^ r.modem_prev))
        else $error("modem change lost");
    bank_efr_a: assert property ( // [RULE17]
        acc && PWRITE_IN && idx == `UBRM_IDX_ISR && r.ctrl.line_control == `UBRM_LCR_ENH
        |=> CTRL_OUT.enhanced_function == $past(wbyte) && $stable(CTRL_OUT.fifo_control))
        else $error("enhanced_function not reached");
endmodule // ubrm_bank

/* File: logic/ubrm_cfg.svh */
/*
 * Offsets, bit positions, masks and reset values of the banked register map.
 * Assumes inclusion by the register bank module and by the bench.
 */
`ifndef UBRM_CFG_SVH
`define UBRM_CFG_SVH

// register indices; the byte address is four times the index
`define UBRM_IDX_DATA 4'h0
`define UBRM_IDX_IER 4'h1
`define UBRM_IDX_ISR 4'h2
`define UBRM_IDX_LCR 4'h3
`define UBRM_IDX_MCR 4'h4
`define UBRM_IDX_LSR 4'h5
`define UBRM_IDX_MSR 4'h6
`define UBRM_IDX_SPR 4'h7
`define UBRM_IDX_TX_FIFO_FILL 4'h8
`define UBRM_IDX_RX_FIFO_FILL 4'h9
`define UBRM_IDX_GPIO_DIRECTION 4'ha
`define UBRM_IDX_IOST 4'hb
`define UBRM_IDX_IOINT 4'hc
`define UBRM_IDX_RSVD 4'hd
`define UBRM_IDX_IOCTL 4'he
`define UBRM_IDX_EXTRA_FEATURES_CONTROL 4'hf

// line_control value that opens the enhanced bank
`define UBRM_LCR_ENH 8'hbf
// bit positions
`define UBRM_DLAB_BIT 7
`define UBRM_ENH_BIT 4
`define UBRM_TSEL_BIT 2
// extended bits, live only while enhanced_function bit 4 is set
`define UBRM_IER_EXT_M 8'hf0
`define UBRM_ISR_EXT_M 6'h30
`define UBRM_FCR_EXT_M 8'h30
`define UBRM_MCR_EXT_M 8'he0
// reset value of every writable register
`define UBRM_RST_REG 8'h00

`endif

/* File: logic/ubrm_pkg.sv */
/*
 * Types of the banked register map: field layouts, selections, carriers.
 * Assumes ubrm_cfg.svh holds the numeric constants.
 */
package ubrm_pkg;
    typedef enum logic [4:0] {
        SEL_NONE, SEL_HOLD, SEL_DLL, SEL_DLM, SEL_DLD, SEL_IER, SEL_ISR, SEL_EFR,
        SEL_LCR, SEL_MCR, SEL_LSR, SEL_MSR, SEL_SPR, SEL_TCR, SEL_TLR, SEL_TX_FIFO_FILL,
        SEL_RX_FIFO_FILL, SEL_GPIO_DIRECTION, SEL_IOST, SEL_IOINT, SEL_IOCTL, SEL_EXTRA_FEATURES_CONTROL,
        SEL_XON1, SEL_XON2, SEL_XOFF1, SEL_XOFF2
    } ubrm_sel_e;
    typedef struct packed {
        logic dlab, tx_break, force_par, even_par, par_en, stop2;
        logic [1:0] wlen;
    } ubrm_lcr_s;
    typedef struct packed {
        logic cts_ie, rts_ie, xoff_ie, sleep_en, modem_ie, rxline_ie, txempty_ie, rxdata_ie;
    } ubrm_ier_s;
    typedef struct packed {
        logic prescale, ir_mode, resume_on_any_char, loopback;
        logic internal_out2, internal_out1, rts, dtr;
    } ubrm_mcr_s;
    typedef struct packed {
        logic [1:0] rx_trig;
        logic [1:0] tx_trig;
        logic spare, tx_reset, rx_reset, fifo_en;
    } ubrm_fcr_s;
    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } ubrm_nib_s;
    typedef struct packed {
        ubrm_lcr_s line_control;
        ubrm_ier_s interrupt_enable;
        ubrm_mcr_s modem_control;
        ubrm_fcr_s fifo_control;
        ubrm_nib_s halt_resume_thresholds, fifo_trigger_levels;
        logic [7:0] dll, baud_divisor_high, baud_divisor_fraction, enhanced_function, scratch_pad, xon1, xon2, xoff1, xoff2;
        logic [7:0] gpio_direction, io_out, io_ie, io_ctl, extra_features_control, tx_data;
    } ubrm_ctrl_s;
    typedef struct packed {
        logic tx_load, rx_pop, rx_fifo_reset, tx_fifo_reset;
    } ubrm_strobe_s;
    typedef struct packed {
        logic [7:0] rx_data;
        logic [7:0] line_status;
        logic [5:0] int_source;
        logic [6:0] tx_fill;
        logic [6:0] rx_fill;
    } ubrm_stat_s;
    typedef struct packed {
        ubrm_ctrl_s ctrl;
        ubrm_strobe_s strobe;
        logic [3:0] modem_meta, modem_sync, modem_prev, modem_delta;
        logic [7:0] gpio_meta, gpio_sync;
        logic [31:0] prdata;
    } ubrm_state_s;
endpackage

/* File: test/ubrm_bank_tb_top.sv */
/*
 * Self-checking bench of the banked register map over apb.
 * Assumes ubrm_path_model stands in for the uart data path.
 */
`timescale 1ns/1ps
`include "ubrm_cfg.svh"
module ubrm_bank_tb_top
    import ubrm_pkg::*;
();
    logic CLK_IN = 1'b0;
    logic RESET_N_IN = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pready;
    logic [5:0] paddr = 6'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [3:0] modem_n = 4'hf;
    logic [7:0] gpio = 8'h96;
    logic [7:0] r;
    logic [7:0] r2;
    logic [32:0] e;
    logic [32:0] expq[$];
    ubrm_stat_s stat;
    ubrm_ctrl_s ctrl;
    ubrm_strobe_s strobe;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 43;

    // 200 MHz clock
    always #2.5 CLK_IN = ~CLK_IN;

    ubrm_bank u_ubrm_bank (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .STAT_IN(stat), .CTRL_OUT(ctrl),
        .STROBE_OUT(strobe), .MODEM_N_IN(modem_n), .GPIO_IN(gpio));
    ubrm_path_model u_ubrm_path_model (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
        .STROBE_IN(strobe), .STAT_OUT(stat));

    task automatic test_done();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK_IN);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge CLK_IN);
        penable <= 1'b1;
        do begin
            @(posedge CLK_IN);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    // note the expected byte, then read
    task automatic rd(input logic [3:0] idx, input logic [7:0] d);
        expq.push_back({1'b0, 24'h0, d});
        xfer(1'b0, idx, 8'h00);
    endtask

    // read data compared when the access completes
    always @(posedge CLK_IN) begin
        cycles <= cycles + 1;
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            e = expq.pop_front();
            if (!e[32]) check(prdata, e[31:0]);
        end
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    // main sequence
    initial begin
        repeat (10) @(posedge CLK_IN);
        RESET_N_IN <= 1'b1;
        rd(`UBRM_IDX_LCR, 8'h00);
        rd(`UBRM_IDX_IER, 8'h00);
        expq.push_back({1'b1, 32'h0});
        xfer(1'b0, `UBRM_IDX_MSR, 8'h00);
        rd(`UBRM_IDX_MSR, 8'h00);
        modem_n <= 4'he;
        repeat (6) @(posedge CLK_IN);
        rd(`UBRM_IDX_MSR, 8'h11);
        rd(`UBRM_IDX_MSR, 8'h10);
        r = $random(seed);
        r[7] = 1'b0;
        wr(`UBRM_IDX_LCR, r);
        check({28'h0, ctrl.line_control.wlen, ctrl.line_control.stop2, ctrl.line_control.tx_break}, {28'h0, r[1:0], r[2], r[6]});
        rd(`UBRM_IDX_LCR, r);
        r2 = $random(seed);
        wr(`UBRM_IDX_SPR, r2);
        rd(`UBRM_IDX_SPR, r2);
        rd(`UBRM_IDX_SPR, r2);
        wr(`UBRM_IDX_LCR, 8'h03);
        wr(`UBRM_IDX_DATA, r2);
        check({23'h0, strobe.tx_load, ctrl.tx_data}, {23'h0, 1'b1, r2});
        rd(`UBRM_IDX_DATA, 8'h41);
        rd(`UBRM_IDX_DATA, 8'h42);
        rd(`UBRM_IDX_RX_FIFO_FILL, 8'h7d);
        rd(`UBRM_IDX_TX_FIFO_FILL, 8'h01);
        rd(`UBRM_IDX_LSR, 8'h61);
        wr(`UBRM_IDX_LSR, 8'hff);
        rd(`UBRM_IDX_LSR, 8'h61);
        rd(`UBRM_IDX_IOST, 8'h96);
        // divisor bank, fraction still locked
        wr(`UBRM_IDX_LCR, 8'h80);
        wr(`UBRM_IDX_DATA, 8'h5a);
        wr(`UBRM_IDX_IER, 8'ha5);
        check({16'h0, ctrl.dll, ctrl.baud_divisor_high}, 32'h5aa5);
        rd(`UBRM_IDX_DATA, 8'h5a);
        rd(`UBRM_IDX_IER, 8'ha5);
        wr(`UBRM_IDX_ISR, 8'h33);
        rd(`UBRM_IDX_ISR, 8'h00);
        rd(`UBRM_IDX_IOST, 8'h00);
        // enhanced bank
        wr(`UBRM_IDX_LCR, 8'hbf);
        wr(`UBRM_IDX_ISR, 8'h10);
        for (int i = 4; i < 8; i++) wr(i[3:0], 8'h20 + i[7:0]);
        for (int i = 4; i < 8; i++) rd(i[3:0], 8'h20 + i[7:0]);
        rd(`UBRM_IDX_ISR, 8'h10);
        check({16'h0, ctrl.xoff2, ctrl.modem_control}, 32'h2700);
        wr(`UBRM_IDX_LCR, 8'h80);
        wr(`UBRM_IDX_ISR, 8'h5a);
        rd(`UBRM_IDX_ISR, 8'h5a);
        wr(`UBRM_IDX_LCR, 8'h00);
        rd(`UBRM_IDX_IER, 8'h00);
        rd(`UBRM_IDX_SPR, r2);
        // extended bits live, alternate selection of 6 and 7
        wr(`UBRM_IDX_IER, 8'hff);
        rd(`UBRM_IDX_IER, 8'hff);
        check({28'h0, ctrl.interrupt_enable.modem_ie, ctrl.interrupt_enable.rxline_ie, ctrl.interrupt_enable.txempty_ie, ctrl.interrupt_enable.rxdata_ie}, 32'hf);
        wr(`UBRM_IDX_MCR, 8'he4);
        rd(`UBRM_IDX_MCR, 8'he4);
        wr(`UBRM_IDX_MSR, 8'ha5);
        wr(`UBRM_IDX_SPR, 8'h3c);
        rd(`UBRM_IDX_MSR, 8'ha5);
        rd(`UBRM_IDX_SPR, 8'h3c);
        check({24'h0, ctrl.halt_resume_thresholds.hi, ctrl.fifo_trigger_levels.lo}, 32'hac);
        wr(`UBRM_IDX_ISR, 8'hf7);
        check({29'h0, strobe.rx_fifo_reset, strobe.tx_fifo_reset, ctrl.fifo_control.fifo_en}, 32'h7);
        check({28'h0, ctrl.fifo_control.rx_trig, ctrl.fifo_control.tx_trig}, 32'hf);
        rd(`UBRM_IDX_ISR, 8'hfc);
        // extended bits hidden again
        wr(`UBRM_IDX_LCR, 8'hbf);
        wr(`UBRM_IDX_ISR, 8'h00);
        wr(`UBRM_IDX_LCR, 8'h00);
        rd(`UBRM_IDX_IER, 8'h0f);
        rd(`UBRM_IDX_MCR, 8'h04);
        rd(`UBRM_IDX_ISR, 8'hcc);
        rd(`UBRM_IDX_SPR, r2);
        // gpio and extra feature registers
        for (int i = 10; i < 16; i++) begin
            r = $random(seed);
            r = r & ((i == 14) ? 8'h03 : 8'hff);
            if (i == 10 || i == 12 || i == 14 || i == 15) begin
                wr(i[3:0], r);
                rd(i[3:0], r);
            end
        end
        wr(`UBRM_IDX_IOST, 8'h3c);
        check({24'h0, ctrl.io_out}, 32'h3c);
        wr(`UBRM_IDX_RSVD, 8'hff);
        rd(`UBRM_IDX_RSVD, 8'h00);
        @(posedge CLK_IN);
        test_done();
    end
endmodule // ubrm_bank_tb_top

/* File: test/ubrm_path_model.sv */
/*
 * Stand-in for the uart data path: rx byte stream, status and fill levels.
 * Assumes the bank's strobes arrive on the same clock.
 */
`timescale 1ns/1ps
module ubrm_path_model
    import ubrm_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    // bank side
    input wire ubrm_strobe_s STROBE_IN,
    output ubrm_stat_s STAT_OUT
);
    // rx byte and fill move on each pop, tx fill counts loads
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            STAT_OUT <= {8'h41, 8'h61, 6'h3c, 7'h00, 7'h7f};
        end else begin
            if (STROBE_IN.rx_pop) begin
                STAT_OUT.rx_data <= STAT_OUT.rx_data + 8'h01;
                STAT_OUT.rx_fill <= STAT_OUT.rx_fill - 7'h01;
            end
            if (STROBE_IN.tx_load) begin
                STAT_OUT.tx_fill <= STAT_OUT.tx_fill + 7'h01;
            end
        end
    end
endmodule // ubrm_path_model
